/* core/sdsp_pkg.sv */
// Notes on behaviour
// - parity byte into buffer B sets its flag
// - overrun drained by buffer B sets its flag
// - overrun drained by buffer A sets its flag
// - read-only next-byte offset for receive buffer A
// - read-only next-byte offset for receive buffer B
// - offset returns to zero when buffer unloads
// - one transmit offset follows the loaded buffer
// - writable 13-bit receive buffer A start address
// - load bit latches addresses, self-clears on completion
// - end address marks where a buffer is full
// - only first error offset per buffer recorded
package sdsp_pkg;
  localparam int          ADDR_W       = 13;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CFG_BASE = 16'h4480;
  localparam logic [15:0] IDX_RXCNT_A  = 16'h4490;
  localparam logic [15:0] IDX_RXCNT_B  = 16'h4492;
  localparam logic [15:0] IDX_TXCNT    = 16'h4494;
  localparam logic [15:0] IDX_STAT     = 16'h4496;
  localparam logic [15:0] IDX_CTRL     = 16'h4498;
  localparam logic [15:0] IDX_ERR_A    = 16'h449A;
  localparam logic [15:0] IDX_ERR_B    = 16'h449C;
  localparam logic [15:0] IDX_INT_STAT = 16'h44A0;
  localparam logic [15:0] IDX_INT_CLR  = 16'h44A2;
  localparam logic [15:0] IDX_INT_EN   = 16'h44A4;
  // field positions
  localparam int          CTRL_RXRST   = 4;
  localparam int          CTRL_TXRST   = 5;
  localparam int          STAT_RXACT   = 0;
  localparam int          STAT_TXACT   = 2;
  localparam int          STAT_OVF     = 4;
  localparam int          STAT_PAR     = 6;
  // reset and fixed values
  localparam logic [12:0] ADDR_RST     = 13'h0000;
  localparam logic [2:0]  CFG_HI_BITS  = 3'h3;
  localparam logic [3:0]  INT_RST      = 4'h0;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_READ  = 4'b0010,
    TX_LATCH = 4'b0100,
    TX_SEND  = 4'b1000
  } sdsp_tx_state_t;
endpackage

/* core/sdsp_core.sv */
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
module sdsp_core
  import sdsp_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [31:0]       adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  output logic                   irq_o,
  // receive fifo side
  input  wire logic              rx_valid_i,
  input  wire logic [7:0]        rx_data_i,
  input  wire logic              rx_par_err_i,
  input  wire logic              rx_overrun_i,
  output logic                   rx_ready_o,
  // transmit fifo side
  input  wire logic              tx_space_i,
  output logic                   tx_valid_o,
  output logic      [7:0]        tx_data_o,
  // buffer ram
  output logic                   mem_we_o,
  output logic      [ADDR_W-1:0] mem_waddr_o,
  output logic      [7:0]        mem_wdata_o,
  output logic                   mem_re_o,
  output logic      [ADDR_W-1:0] mem_raddr_o,
  input  wire logic [7:0]        mem_rdata_i
);
  ////////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0] cfg_reg     [8];
  logic [ADDR_W-1:0] lat_beg_reg [4];
  logic [ADDR_W-1:0] lat_end_reg [4];
  logic [ADDR_W-1:0] rx_cnt_reg  [2];
  logic [ADDR_W-1:0] err_off_reg [2];
  logic [ADDR_W-1:0] tx_cnt_reg;
  logic [3:0]        load_reg;
  logic [1:0]        par_reg;
  logic [1:0]        ovf_reg;
  logic [1:0]        err_seen_reg;
  logic              rx_sel_b_reg;
  logic              tx_sel_b_reg;
  logic              rx_ready_reg;
  logic [3:0]        int_stat_reg;
  logic [3:0]        int_en_reg;
  logic              irq_reg;
  logic              ack_reg;
  logic [31:0]       dat_reg;
  logic              tx_valid_reg;
  logic [7:0]        tx_data_reg;
  logic              mem_we_reg;
  logic [ADDR_W-1:0] mem_waddr_reg;
  logic [7:0]        mem_wdata_reg;
  logic              mem_re_reg;
  logic [ADDR_W-1:0] mem_raddr_reg;
  sdsp_tx_state_t    tx_state_reg;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic              req;
  logic              wr;
  logic [15:0]       idx;
  logic              ctrl_wr;
  logic              cfg_hit;
  logic              rx_rst;
  logic              tx_rst;
  logic [3:0]        load_new;
  logic [3:0]        done;
  logic [ADDR_W-1:0] wdat_low;
  assign req      = cyc_i & stb_i & ~ack_reg;
  assign wr       = req & we_i;
  assign idx      = adr_i[17:2];
  assign wdat_low = dat_i[ADDR_W-1:0];
  assign cfg_hit  = (idx[15:4] == IDX_CFG_BASE[15:4]) & ~idx[0];
  assign ctrl_wr  = wr & sel_i[0] & (idx == IDX_CTRL);
  assign rx_rst   = ctrl_wr & dat_i[CTRL_RXRST];
  assign tx_rst   = ctrl_wr & dat_i[CTRL_TXRST];
  // setting an already pending buffer has no further effect
  assign load_new = ctrl_wr ? (dat_i[3:0] & ~load_reg) : 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // receive path
  logic              rx_cur;
  logic              rx_take;
  logic              rx_last;
  logic              rx_err;
  logic [ADDR_W-1:0] rx_addr;
  assign rx_cur  = rx_sel_b_reg;
  assign rx_take = rx_valid_i & rx_ready_reg & ~rx_rst;
  assign rx_addr = lat_beg_reg[rx_cur] + rx_cnt_reg[rx_cur];
  assign rx_last = rx_addr == lat_end_reg[rx_cur];
  assign rx_err  = rx_par_err_i | rx_overrun_i;
  // transmit path
  logic              tx_cur;
  logic              tx_last;
  logic [ADDR_W-1:0] tx_addr;
  assign tx_cur  = tx_sel_b_reg;
  assign tx_addr = lat_beg_reg[{1'b1, tx_cur}] + tx_cnt_reg;
  assign tx_last = tx_addr == lat_end_reg[{1'b1, tx_cur}];
  assign done[0] = rx_take & ~rx_cur & rx_last;
  assign done[1] = rx_take & rx_cur & rx_last;
  assign done[2] = (tx_state_reg == TX_SEND) & ~tx_cur & tx_last & ~tx_rst;
  assign done[3] = (tx_state_reg == TX_SEND) & tx_cur & tx_last & ~tx_rst;

  ////////////////////////////////////////////////////////////////////////
  // address registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 8; k++) begin
      if (rst_i) begin
        cfg_reg[k] <= ADDR_RST;
      end else if (wr & cfg_hit & (idx[3:1] == k[2:0])) begin
        if (sel_i[0]) cfg_reg[k][7:0] <= wdat_low[7:0];
        if (sel_i[1]) cfg_reg[k][12:8] <= wdat_low[12:8];
      end
    end
  end

  // load bits and address latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_reg <= 4'h0;
    end else begin
      load_reg <= ((load_reg & ~done) | load_new)
                  & ~{tx_rst, tx_rst, rx_rst, rx_rst};
    end
    for (int i = 0; i < 4; i++) begin
      if (rst_i) begin
        lat_beg_reg[i] <= ADDR_RST;
        lat_end_reg[i] <= ADDR_RST;
      end else if (load_new[i]) begin
        lat_beg_reg[i] <= cfg_reg[2*i];
        lat_end_reg[i] <= cfg_reg[2*i+1];
      end
    end
  end

  // receive buffer selection and flow control
  always_ff @(posedge clk_i) begin
    if (rst_i | rx_rst) begin
      rx_sel_b_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
    end else begin
      if (rx_take & rx_last) rx_sel_b_reg <= ~rx_sel_b_reg;
      rx_ready_reg <= load_reg[rx_cur] & ~rx_take;
    end
  end

  // per-buffer offsets, flags and first error
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i | rx_rst | load_new[i]) begin
        rx_cnt_reg[i]   <= ADDR_RST;
        par_reg[i]      <= 1'b0;
        ovf_reg[i]      <= 1'b0;
        err_off_reg[i]  <= ADDR_RST;
        err_seen_reg[i] <= 1'b0;
      end else if (rx_take & (rx_cur == i[0])) begin
        rx_cnt_reg[i] <= rx_last ? ADDR_RST : rx_cnt_reg[i] + 1'b1;
        if (rx_par_err_i) par_reg[i] <= 1'b1;
        if (rx_overrun_i) ovf_reg[i] <= 1'b1;
        if (rx_err & ~err_seen_reg[i]) begin
          err_off_reg[i]  <= rx_cnt_reg[i];
          err_seen_reg[i] <= 1'b1;
        end
      end
    end
  end

  // ram write port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_reg    <= 1'b0;
      mem_waddr_reg <= ADDR_RST;
      mem_wdata_reg <= 8'h00;
    end else begin
      mem_we_reg    <= rx_take;
      mem_waddr_reg <= rx_addr;
      mem_wdata_reg <= rx_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencer: read ram, latch byte, push one byte to fifo
  always_ff @(posedge clk_i) begin
    if (rst_i | tx_rst) begin
      tx_state_reg  <= TX_IDLE;
      tx_sel_b_reg  <= 1'b0;
      tx_cnt_reg    <= ADDR_RST;
      tx_valid_reg  <= 1'b0;
      tx_data_reg   <= 8'h00;
      mem_re_reg    <= 1'b0;
      mem_raddr_reg <= ADDR_RST;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          if (load_reg[{1'b1, tx_cur}] & tx_space_i) begin
            mem_re_reg    <= 1'b1;
            mem_raddr_reg <= tx_addr;
            tx_state_reg  <= TX_READ;
          end
        end
        TX_READ: begin
          mem_re_reg   <= 1'b0;
          tx_state_reg <= TX_LATCH;
        end
        TX_LATCH: begin
          tx_data_reg  <= mem_rdata_i;
          tx_valid_reg <= 1'b1;
          tx_state_reg <= TX_SEND;
        end
        TX_SEND: begin
          tx_valid_reg <= 1'b0;
          tx_cnt_reg   <= tx_last ? ADDR_RST : tx_cnt_reg + 1'b1;
          if (tx_last) tx_sel_b_reg <= ~tx_sel_b_reg;
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: {par B, par A, ovf B, ovf A}; set wins over clear
  logic [3:0] ev;
  logic       take_a;
  logic       take_b;
  assign take_a = rx_take & ~rx_cur;
  assign take_b = rx_take & rx_cur;
  assign ev     = {take_b & rx_par_err_i, take_a & rx_par_err_i,
                   take_b & rx_overrun_i, take_a & rx_overrun_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_reg <= INT_RST;
      int_en_reg   <= INT_RST;
      irq_reg      <= 1'b0;
    end else begin
      int_stat_reg <= (int_stat_reg
                       & ~((wr & sel_i[0] & (idx == IDX_INT_CLR)) ? dat_i[3:0] : 4'h0))
                      | ev;
      if (wr & sel_i[0] & (idx == IDX_INT_EN)) int_en_reg <= dat_i[3:0];
      irq_reg <= |(int_stat_reg & int_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge
  logic [15:0] rd;
  always_comb begin
    rd = 16'h0000;
    if (cfg_hit) begin
      rd = {1'b0, CFG_HI_BITS[1:0], cfg_reg[idx[3:1]]};
    end else begin
      unique case (idx)
        IDX_RXCNT_A:  rd = {3'h0, rx_cnt_reg[0]};
        IDX_RXCNT_B:  rd = {3'h0, rx_cnt_reg[1]};
        IDX_TXCNT:    rd = {3'h0, tx_cnt_reg};
        IDX_STAT:     rd = {8'h00, par_reg, ovf_reg,
                            load_reg[3] & tx_cur, load_reg[2] & ~tx_cur,
                            load_reg[1] & rx_cur, load_reg[0] & ~rx_cur};
        IDX_CTRL:     rd = {12'h000, load_reg};
        IDX_ERR_A:    rd = {3'h0, err_off_reg[0]};
        IDX_ERR_B:    rd = {3'h0, err_off_reg[1]};
        IDX_INT_STAT: rd = {12'h000, int_stat_reg};
        IDX_INT_EN:   rd = {12'h000, int_en_reg};
        default:      rd = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      dat_reg <= {16'h0000, rd};
    end
  end

  assign dat_o       = dat_reg;
  assign ack_o       = ack_reg;
  assign irq_o       = irq_reg;
  assign rx_ready_o  = rx_ready_reg;
  assign tx_valid_o  = tx_valid_reg;
  assign tx_data_o   = tx_data_reg;
  assign mem_we_o    = mem_we_reg;
  assign mem_waddr_o = mem_waddr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign mem_re_o    = mem_re_reg;
  assign mem_raddr_o = mem_raddr_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  par_b_set_a: assert property (take_b & rx_par_err_i |=> par_reg[1] & int_stat_reg[3])
    else $error("parity B flag not set");
  par_a_set_a: assert property (take_a & rx_par_err_i |=> par_reg[0] & int_stat_reg[2])
    else $error("parity A flag not set");
  ovf_b_set_a: assert property (take_b & rx_overrun_i |=> ovf_reg[1])
    else $error("overrun B flag not set");
  ovf_a_set_a: assert property (take_a & rx_overrun_i |=> ovf_reg[0])
    else $error("overrun A flag not set");
  cnt_a_step_a: assert property (take_a & ~rx_last
    |=> rx_cnt_reg[0] == $past(rx_cnt_reg[0]) + 1'b1)
    else $error("offset A did not step");
  cnt_b_step_a: assert property (take_b & ~rx_last
    |=> rx_cnt_reg[1] == $past(rx_cnt_reg[1]) + 1'b1)
    else $error("offset B did not step");
  wrap_unload_a: assert property (take_a & rx_last
    |=> rx_cnt_reg[0] == ADDR_RST && !load_reg[0] && rx_sel_b_reg)
    else $error("buffer A did not unload to zero");
  tx_cnt_step_a: assert property (tx_state_reg == TX_SEND && !tx_last && !tx_rst
    |=> tx_cnt_reg == $past(tx_cnt_reg) + 1'b1 ##1 !tx_valid_o)
    else $error("transmit offset did not step");
  beg_write_a: assert property (wr && idx == IDX_CFG_BASE && sel_i[1:0] == 2'h3
    |=> cfg_reg[0] == $past(wdat_low))
    else $error("start address A not stored");
  beg_read_a: assert property (req && !we_i && cfg_hit |=> ack_o && dat_o[15:13] == 3'h3)
    else $error("upper address bits wrong");
  load_latch_a: assert property (load_new[0] && !rx_rst
    |=> load_reg[0] && lat_beg_reg[0] == $past(cfg_reg[0]))
    else $error("load did not latch");
  end_full_a: assert property (take_b && rx_last |=> !load_reg[1])
    else $error("buffer B not released at end");
  first_err_a: assert property (err_seen_reg[0] && !rx_rst && !load_new[0]
    |=> $stable(err_off_reg[0]))
    else $error("first error offset overwritten");
  ack_pulse_a: assert property (req |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");
  fill_a_c: cover property (take_a && rx_last);
  swap_b_c: cover property (done[0] ##[1:50] take_b);
  tx_byte_c: cover property (tx_state_reg == TX_SEND && tx_last);
  irq_c: cover property (irq_o);
endmodule

/* test/sdsp_fifo_model.sv */
`timescale 1ns/1ns
module sdsp_fifo_model
  import sdsp_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // receive fifo
  output logic                   rx_valid_o,
  output logic      [7:0]        rx_data_o,
  output logic                   rx_par_err_o,
  output logic                   rx_overrun_o,
  input  wire logic              rx_ready_i,
  // transmit fifo
  output logic                   tx_space_o,
  input  wire logic              tx_valid_i,
  input  wire logic [7:0]        tx_data_i,
  // buffer ram
  input  wire logic              mem_we_i,
  input  wire logic [ADDR_W-1:0] mem_waddr_i,
  input  wire logic [7:0]        mem_wdata_i,
  input  wire logic              mem_re_i,
  input  wire logic [ADDR_W-1:0] mem_raddr_i,
  output logic      [7:0]        mem_rdata_o
);
  logic [9:0] rxq[$];
  logic [7:0] txq[$];
  logic [7:0] ram [0:8191];

  initial begin
    {rx_valid_o, rx_overrun_o, rx_par_err_o, rx_data_o} = 11'h000;
    tx_space_o = 1'b0;
    mem_rdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////
  // byte and its flags held until taken; scrambled when nothing offered
  always @(posedge clk_i) begin
    if (rx_valid_o && rx_ready_i) begin
      void'(rxq.pop_front());
    end
    rx_valid_o <= (rxq.size() != 0);
    if (rxq.size() != 0) begin
      {rx_overrun_o, rx_par_err_o, rx_data_o} <= rxq[0];
    end else begin
      {rx_overrun_o, rx_par_err_o, rx_data_o} <= ~{rx_overrun_o, rx_par_err_o, rx_data_o};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmit side stalls at random
  always @(posedge clk_i) begin
    tx_space_o <= ($urandom_range(3) != 0);
    if (tx_valid_i) begin
      txq.push_back(tx_data_i);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ram: read data valid the cycle after the strobe only
  always @(posedge clk_i) begin
    if (mem_we_i) begin
      ram[mem_waddr_i] <= mem_wdata_i;
    end
    mem_rdata_o <= mem_re_i ? ram[mem_raddr_i] : ~mem_rdata_o;
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench
  import sdsp_pkg::*;
;
  logic              clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0]       adr_i = 32'h0, dat_i = 32'h0, dat_o;
  logic [3:0]        sel_i = 4'h3;
  logic              ack_o, irq_o, rx_valid, rx_par, rx_ovf, rx_ready_o, tx_space, tx_valid_o;
  logic              mem_we_o, mem_re_o;
  logic [7:0]        rx_data, tx_data_o, mem_wdata_o, mem_rdata;
  logic [ADDR_W-1:0] mem_waddr_o, mem_raddr_o;
  logic [15:0]       rd;
  logic [7:0]        mdl [int];
  int                num_errors = 0, compares = 0, cycles = 0;

  always #10 clk_i = ~clk_i;

  sdsp_core i_sdsp_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_par_err_i(rx_par),
    .rx_overrun_i(rx_ovf), .rx_ready_o(rx_ready_o), .tx_space_i(tx_space),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .mem_we_o(mem_we_o),
    .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .mem_re_o(mem_re_o),
    .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata));

  sdsp_fifo_model i_sdsp_fifo_model (.clk_i(clk_i), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_par_err_o(rx_par), .rx_overrun_o(rx_ovf),
    .rx_ready_i(rx_ready_o), .tx_space_o(tx_space), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .mem_we_i(mem_we_o), .mem_waddr_i(mem_waddr_o),
    .mem_wdata_i(mem_wdata_o), .mem_re_i(mem_re_o), .mem_raddr_i(mem_raddr_o),
    .mem_rdata_o(mem_rdata));

  ////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single classic cycle, held until ack
  task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= {14'h0000, idx, 2'h0};
    dat_i <= {16'h0000, wd};
    // ack_o ends this wait; only the global cycle ceiling bounds it
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    check(rd, exp);
  endtask

  task automatic poll(input logic [15:0] idx, input logic [15:0] exp);
    int n;
    n = 0;
    do begin
      wb(1'b0, idx, 16'h0000);
      n++;
    end while (rd !== exp && n < 300);
    check(rd, exp);
  endtask

  task automatic push(input int a, input logic par, input logic ovf);
    logic [7:0] d;
    d = 8'($urandom);
    mdl[a] = d;
    i_sdsp_fifo_model.rxq.push_back({ovf, par, d});
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(49901));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(IDX_CFG_BASE, 16'h6000);
    rchk(IDX_RXCNT_B, 16'h0000);
    rchk(IDX_TXCNT, 16'h0000);
    rchk(16'h4600, 16'h0000);
    wb(1'b1, IDX_CFG_BASE, 16'hFFFF);
    rchk(IDX_CFG_BASE, 16'h7FFF);
    wb(1'b1, IDX_RXCNT_A, 16'h0055);
    rchk(IDX_RXCNT_A, 16'h0000);
    $display("test registers done");
    wb(1'b1, IDX_CFG_BASE, 16'h0100);
    wb(1'b1, 16'h4482, 16'h0103);
    wb(1'b1, 16'h4484, 16'h0200);
    wb(1'b1, 16'h4486, 16'h0201);
    wb(1'b1, IDX_CTRL, 16'h0003);
    rchk(IDX_CTRL, 16'h0003);
    rchk(IDX_STAT, 16'h0001);
    push(256, 1'b0, 1'b0);
    push(257, 1'b1, 1'b0);
    poll(IDX_RXCNT_A, 16'h0002);
    push(258, 1'b1, 1'b0);
    push(259, 1'b0, 1'b0);
    push(512, 1'b0, 1'b0);
    poll(IDX_RXCNT_B, 16'h0001);
    rchk(IDX_RXCNT_A, 16'h0000);
    push(513, 1'b1, 1'b0);
    poll(IDX_CTRL, 16'h0000);
    rchk(IDX_RXCNT_B, 16'h0000);
    rchk(IDX_STAT, 16'h00C0);
    rchk(IDX_ERR_A, 16'h0001);
    rchk(IDX_ERR_B, 16'h0001);
    $display("test receive done");
    rchk(IDX_INT_STAT, 16'h000C);
    wb(1'b1, IDX_INT_EN, 16'h0004);
    @(negedge clk_i);
    check({15'h0000, irq_o}, 16'h0001);
    wb(1'b1, IDX_INT_CLR, 16'h0004);
    rchk(IDX_INT_STAT, 16'h0008);
    @(negedge clk_i);
    check({15'h0000, irq_o}, 16'h0000);
    wb(1'b1, IDX_INT_EN, 16'h0000);
    $display("test interrupt done");
    wb(1'b1, 16'h4482, 16'h0100);
    push(256, 1'b0, 1'b1);
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    check({15'h0000, rx_ready_o}, 16'h0000);
    wb(1'b1, IDX_CTRL, 16'h0001);
    poll(IDX_CTRL, 16'h0000);
    rchk(IDX_STAT, 16'h0090);
    push(512, 1'b0, 1'b1);
    push(513, 1'b0, 1'b0);
    repeat (6) @(posedge clk_i);
    wb(1'b1, IDX_CTRL, 16'h0002);
    poll(IDX_CTRL, 16'h0000);
    rchk(IDX_STAT, 16'h0030);
    $display("test overrun done");
    wb(1'b1, 16'h4488, 16'h0100);
    wb(1'b1, 16'h448A, 16'h0103);
    wb(1'b1, IDX_CTRL, 16'h0004);
    poll(IDX_CTRL, 16'h0000);
    rchk(IDX_TXCNT, 16'h0000);
    check(16'(i_sdsp_fifo_model.txq.size()), 16'h0004);
    for (int i = 0; i < 4; i++) begin
      check({8'h00, i_sdsp_fifo_model.txq[i]}, {8'h00, mdl[256 + i]});
    end
    foreach (mdl[a]) begin
      check({8'h00, i_sdsp_fifo_model.ram[a]}, {8'h00, mdl[a]});
    end
    $display("test transmit done");
    // transmit reset beats a load of buffer B in the same write
    wb(1'b1, IDX_CTRL, 16'h0028);
    rchk(IDX_CTRL, 16'h0000);
    repeat (10) @(posedge clk_i);
    check(16'(i_sdsp_fifo_model.txq.size()), 16'h0004);
    rchk(IDX_TXCNT, 16'h0000);
    $display("test tx reset done");
    wb(1'b1, IDX_CTRL, 16'h0010);
    rchk(IDX_STAT, 16'h0000);
    $display("test rx reset done");
    tally_and_finish;
  end
endmodule
